// *** rtl/wdtru_pkg.sv ***
package wdtru_pkg;

  // ==========================================================
  // Clocking and oscillator
  // ==========================================================
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned OSC_HZ       = 128_000;
  // Integer divide: the derived oscillator runs slightly fast
  localparam int unsigned TICK_DIV_CYC = CLK_HZ / OSC_HZ;

  // ==========================================================
  // Time-out selection
  // ==========================================================
  localparam int unsigned TMO_MIN_MS   = 16;
  localparam int unsigned TMO_MAX_S    = 8;
  localparam int unsigned SEL_W        = 4;
  localparam int unsigned CNT_W        = 20;
  localparam int unsigned BASE_TICKS   = 2048;
  localparam logic [SEL_W-1:0] SEL_MAX = 4'h9;
  localparam logic [SEL_W-1:0] SEL_RST = 4'h0;

  // ==========================================================
  // Change window and reset pulse
  // ==========================================================
  localparam int unsigned CHG_WINDOW_CYC = 4;
  localparam logic [2:0]  CHG_LOAD       = 3'h4;
  localparam int unsigned RST_PULSE_CYC  = 1;

  // ==========================================================
  // Control word and modes
  // ==========================================================
  typedef struct packed {
    logic             irqFlag;
    logic             irqEn;
    logic             changeEn;
    logic             resetEn;
    logic [SEL_W-1:0] tmoSel;
  } wdtru_ctl_s;

  typedef enum logic [1:0] {
    MODE_STOPPED,
    MODE_IRQ,
    MODE_RESET,
    MODE_IRQ_RESET
  } wdtru_mode_e;

endpackage

// *** rtl/wdtru_tmo_counter.sv ***
`timescale 1ns/10ps
module wdtru_tmo_counter #(
  parameter int unsigned TICK_DIV = wdtru_pkg::TICK_DIV_CYC
) (
  // Clock and reset
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Control
  input  wire logic                       run,
  input  wire logic                       restart,
  input  wire logic [wdtru_pkg::SEL_W-1:0] tmoSel,
  // Status
  output logic                            expire,
  output logic [wdtru_pkg::CNT_W-1:0]     tickCnt
);

  // The divider is 16 bits wide and needs at least two phases
  if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_div
    $error("TICK_DIV out of range");
  end

  // ==========================================================
  // Oscillator tick enable
  // ==========================================================
  logic [15:0] divCnt_q;
  logic        tick;
  logic [wdtru_pkg::SEL_W-1:0] effSel;
  logic [wdtru_pkg::CNT_W:0]   limit;

  assign tick = (divCnt_q == 16'(TICK_DIV - 1));

  always_ff @(posedge mclk) begin
    if (!reset_n || tick) begin
      divCnt_q <= 16'h0000;
    end else begin
      divCnt_q <= divCnt_q + 16'h0001;
    end
  end

  // ==========================================================
  // Time-out count
  // ==========================================================
  // Reserved codes fall back to the longest period
  assign effSel = (tmoSel > wdtru_pkg::SEL_MAX) ? wdtru_pkg::SEL_MAX
                                                 : tmoSel;
  assign limit  = (wdtru_pkg::CNT_W+1)'(wdtru_pkg::BASE_TICKS) << effSel;

  always_ff @(posedge mclk) begin
    if (!reset_n || restart || !run) begin
      tickCnt <= '0;
    end else if (tick && !expire) begin
      tickCnt <= tickCnt + 1'b1;
    end
  end

  // Greater-or-equal so a shortened period times out at once
  always_ff @(posedge mclk) begin
    if (!reset_n || restart || !run) begin
      expire <= 1'b0;
    end else begin
      expire <= tick && !expire &&
                ({1'b0, tickCnt} + 21'h000001 >= limit);
    end
  end

  a_restart_zero: assert property (@(posedge mclk) disable iff (!reset_n)
    restart |=> (tickCnt == '0) && !expire)
    else $error("counter not cleared by restart");

  a_expire_pulse: assert property (@(posedge mclk) disable iff (!reset_n)
    expire |=> !expire)
    else $error("expiry lasted more than one cycle");

endmodule

// *** rtl/wdtru_watchdog.sv ***
`timescale 1ns/10ps
module wdtru_watchdog #(
  parameter int unsigned TICK_DIV = wdtru_pkg::TICK_DIV_CYC
) (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  // Fuse pin, low when programmed
  input  wire logic                  alwaysOnFuseN,
  // Core requests
  input  wire logic                  ctlWrEn,
  input  wire wdtru_pkg::wdtru_ctl_s ctlWrData,
  input  wire logic                  restartReq,
  input  wire logic                  irqAck,
  input  wire logic                  causeClr,
  // Status to core
  output wdtru_pkg::wdtru_ctl_s      ctlRd,
  output logic                       causeFlag_q,
  output logic                       irqReq_q,
  output logic                       sysReset_q
);

  // ==========================================================
  // State
  // ==========================================================
  logic                        fuseS1_q;
  logic                        fuseS2_q;
  logic                        fuseS3_q;
  logic                        fuseOn_q;
  logic [2:0]                  chgCnt_q;
  logic                        resetEn_q;
  logic                        irqEn_q;
  logic                        irqFlag_q;
  logic [wdtru_pkg::SEL_W-1:0] tmoSel_q;
  wdtru_pkg::wdtru_mode_e      mode;
  logic                        winOpen_q;
  logic                        winOpen;
  logic                        stepOne;
  logic                        stepTwo;
  logic                        expire;
  logic                        rstFire;
  logic                        irqExpire;
  logic                        cntRestart;
  logic [wdtru_pkg::CNT_W-1:0] tickCnt;

  // ==========================================================
  // Fuse pin synchroniser
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fuseS1_q <= 1'b1;
      fuseS2_q <= 1'b1;
      fuseS3_q <= 1'b1;
    end else begin
      fuseS1_q <= alwaysOnFuseN;
      fuseS2_q <= fuseS1_q;
      fuseS3_q <= fuseS2_q;
    end
  end

  // A change is accepted only once two stages agree
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      fuseOn_q <= 1'b0;
    end else if (fuseS2_q == fuseS3_q) begin
      fuseOn_q <= !fuseS3_q;
    end
  end

  // ==========================================================
  // Mode decode
  // ==========================================================
  always_comb begin
    case ({fuseOn_q, resetEn_q, irqEn_q})
      3'b000:  mode = wdtru_pkg::MODE_STOPPED;
      3'b001:  mode = wdtru_pkg::MODE_IRQ;
      3'b010:  mode = wdtru_pkg::MODE_RESET;
      3'b011:  mode = wdtru_pkg::MODE_IRQ_RESET;
      default: mode = wdtru_pkg::MODE_RESET;
    endcase
  end

  // ==========================================================
  // Timed change sequence
  // ==========================================================
  assign winOpen = winOpen_q;
  assign stepOne = ctlWrEn && ctlWrData.changeEn &&
                   ctlWrData.resetEn;
  assign stepTwo = ctlWrEn && !ctlWrData.changeEn && winOpen;

  always_ff @(posedge mclk) begin
    if (!reset_n || rstFire) begin
      chgCnt_q <= 3'h0;
    end else if (stepOne) begin
      chgCnt_q <= wdtru_pkg::CHG_LOAD;
    end else if (stepTwo) begin
      chgCnt_q <= 3'h0;
    end else if (winOpen) begin
      chgCnt_q <= chgCnt_q - 3'h1;
    end
  end

  // Registered so the readback bit comes straight from a flop
  always_ff @(posedge mclk) begin
    if (!reset_n || rstFire) begin
      winOpen_q <= 1'b0;
    end else if (stepOne) begin
      winOpen_q <= 1'b1;
    end else if (stepTwo) begin
      winOpen_q <= 1'b0;
    end else if (winOpen_q) begin
      winOpen_q <= (chgCnt_q != 3'h1);
    end
  end

  // ==========================================================
  // Expiry decode
  // ==========================================================
  // Single clock: oscillator tick is an enable, so the restart and
  // configuration reach the counter and expiry returns in one cycle
  // Every expiry restarts the count, so a combined-mode reset only
  // follows a full second period after the interrupt
  assign cntRestart = restartReq || expire;
  assign rstFire    = expire &&
                      (mode == wdtru_pkg::MODE_RESET ||
                       (mode == wdtru_pkg::MODE_IRQ_RESET &&
                        irqFlag_q));
  assign irqExpire  = expire &&
                      (mode == wdtru_pkg::MODE_IRQ ||
                       (mode == wdtru_pkg::MODE_IRQ_RESET &&
                        !irqFlag_q));

  wdtru_tmo_counter #(
    .TICK_DIV (TICK_DIV)
  ) u_counter (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .run      (mode != wdtru_pkg::MODE_STOPPED),
    .restart  (cntRestart),
    .tmoSel   (tmoSel_q),
    .expire   (expire),
    .tickCnt  (tickCnt)
  );

  // ==========================================================
  // Reset enable
  // ==========================================================
  // Cause flag keeps the watchdog alive across its own reset
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resetEn_q <= 1'b0;
    end else if (fuseOn_q || causeFlag_q || rstFire) begin
      resetEn_q <= 1'b1;
    end else if (stepTwo) begin
      resetEn_q <= ctlWrData.resetEn;
    end else if (ctlWrEn && ctlWrData.resetEn) begin
      resetEn_q <= 1'b1;
    end
  end

  // ==========================================================
  // Time-out selection
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!reset_n || rstFire) begin
      tmoSel_q <= wdtru_pkg::SEL_RST;
    end else if (stepTwo) begin
      tmoSel_q <= ctlWrData.tmoSel;
    end
  end

  // ==========================================================
  // Interrupt enable and flag
  // ==========================================================
  // In combined mode, vector acknowledge wins over a same-cycle enable write
  always_ff @(posedge mclk) begin
    if (!reset_n || rstFire || fuseOn_q) begin
      irqEn_q <= 1'b0;
    end else if (irqAck && mode == wdtru_pkg::MODE_IRQ_RESET) begin
      irqEn_q <= 1'b0;
    end else if (ctlWrEn) begin
      irqEn_q <= ctlWrData.irqEn;
    end
  end

  // Set wins over acknowledge and write-one clear
  always_ff @(posedge mclk) begin
    if (!reset_n || rstFire) begin
      irqFlag_q <= 1'b0;
    end else if (irqExpire) begin
      irqFlag_q <= 1'b1;
    end else if (irqAck || (ctlWrEn && ctlWrData.irqFlag)) begin
      irqFlag_q <= 1'b0;
    end
  end

  // Level request, not gated by sleep so it can wake the core
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      irqReq_q <= 1'b0;
    end else begin
      irqReq_q <= irqFlag_q && irqEn_q && !rstFire;
    end
  end

  // ==========================================================
  // Reset pulse and cause flag
  // ==========================================================
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sysReset_q <= 1'b0;
    end else begin
      sysReset_q <= rstFire && !sysReset_q;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      causeFlag_q <= 1'b0;
    end else if (rstFire) begin
      causeFlag_q <= 1'b1;
    end else if (causeClr) begin
      causeFlag_q <= 1'b0;
    end
  end

  assign ctlRd = '{irqFlag:  irqFlag_q,
                   irqEn:    irqEn_q,
                   changeEn: winOpen_q,
                   resetEn:  resetEn_q,
                   tmoSel:   tmoSel_q};

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_step_one;
    stepOne;
  endsequence

  sequence s_quiet4;
    (!ctlWrEn && !rstFire) [*4];
  endsequence

  a_reset_pulse_one: assert property (sysReset_q |=> !sysReset_q)
    else $error("reset pulse longer than one cycle");

  a_reset_on_expiry: assert property (
    rstFire |=> sysReset_q && causeFlag_q && resetEn_q)
    else $error("expiry in reset mode gave no reset");

  a_irq_on_expiry: assert property (
    irqExpire |=> irqFlag_q ##1 (irqReq_q || !irqEn_q))
    else $error("expiry in interrupt mode gave no interrupt");

  a_combined_first: assert property (
    expire && mode == wdtru_pkg::MODE_IRQ_RESET && !irqFlag_q
    |=> !sysReset_q && irqFlag_q)
    else $error("combined mode first expiry wrong");

  a_fuse_lock: assert property (
    fuseOn_q |=> resetEn_q && !irqEn_q)
    else $error("fuse did not lock reset mode");

  a_guard_outside: assert property (
    !winOpen && !rstFire |=> $stable(tmoSel_q) && !$fell(resetEn_q))
    else $error("protected field changed outside window");

  a_step_two_taken: assert property (
    stepTwo && !rstFire |=> tmoSel_q == $past(ctlWrData.tmoSel))
    else $error("step two write not honoured");

  a_window_closes: assert property (
    s_step_one ##1 s_quiet4 |=> !winOpen)
    else $error("change enable not cleared after four cycles");

  a_cause_holds_en: assert property (causeFlag_q |-> resetEn_q)
    else $error("reset enable clear while cause flag set");

  a_vector_clears: assert property (
    irqAck && mode == wdtru_pkg::MODE_IRQ_RESET && !irqExpire
    |=> !irqEn_q && !irqFlag_q && resetEn_q)
    else $error("vector did not leave reset mode");

endmodule

// *** sim/wdtru_core_model.sv ***
`timescale 1ns/10ps
module wdtru_core_model (
  // Clock
  input  wire logic             mclk,
  // Requests to the watchdog
  output wdtru_pkg::wdtru_ctl_s ctlWrData,
  output logic                  ctlWrEn,
  output logic                  restartReq,
  output logic                  irqAck,
  output logic                  causeClr
);
  // ==========================================================
  // Core stores and instruction pulses
  // ==========================================================
  initial begin
    ctlWrEn    = 1'b0;
    ctlWrData  = '0;
    restartReq = 1'b0;
    irqAck     = 1'b0;
    causeClr   = 1'b0;
  end

  // Data is inverted once the strobe drops so nothing stale is seen
  task automatic write(input wdtru_pkg::wdtru_ctl_s d);
    @(negedge mclk);
    ctlWrEn   = 1'b1;
    ctlWrData = d;
    @(negedge mclk);
    ctlWrEn   = 1'b0;
    ctlWrData = ~d;
  endtask

  // Both steps back to back, well inside the four-cycle window
  task automatic timed(input wdtru_pkg::wdtru_ctl_s cur,
                       input wdtru_pkg::wdtru_ctl_s d);
    wdtru_pkg::wdtru_ctl_s s;
    s          = cur;
    s.irqFlag  = 1'b0;
    s.changeEn = 1'b1;
    s.resetEn  = 1'b1;
    @(negedge mclk);
    ctlWrEn    = 1'b1;
    ctlWrData  = s;
    s          = d;
    s.changeEn = 1'b0;
    @(negedge mclk);
    ctlWrData  = s;
    @(negedge mclk);
    ctlWrEn   = 1'b0;
    ctlWrData = ~d;
  endtask

  // 0 restart, 1 vector executed, 2 cause flag cleared
  task automatic pulse(input int which);
    @(negedge mclk);
    restartReq = (which == 0);
    irqAck     = (which == 1);
    causeClr   = (which == 2);
    @(negedge mclk);
    restartReq = 1'b0;
    irqAck     = 1'b0;
    causeClr   = 1'b0;
  endtask
endmodule

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
  // Short oscillator divider keeps the periods used here (codes 0 and 1) at 4096 and 8192 cycles
  localparam int unsigned TDIV = 2;
  logic                  mclk;
  logic                  reset_n;
  logic                  alwaysOnFuseN;
  logic                  ctlWrEn;
  logic                  restartReq;
  logic                  irqAck;
  logic                  causeClr;
  logic                  causeFlag_q;
  logic                  irqReq_q;
  logic                  sysReset_q;
  wdtru_pkg::wdtru_ctl_s ctlWrData;
  wdtru_pkg::wdtru_ctl_s ctlRd;
  wdtru_pkg::wdtru_ctl_s d;
  int                    errors;
  int                    nCompared;
  int                    seed;
  int                    nRst;
  int                    n;
  int                    mF;
  int                    mIe;
  int                    mRe;
  int                    mSel;
  int                    tmoQ[$];

  wdtru_watchdog #(.TICK_DIV(TDIV)) u_dut (
    .mclk(mclk), .reset_n(reset_n), .alwaysOnFuseN(alwaysOnFuseN),
    .ctlWrEn(ctlWrEn), .ctlWrData(ctlWrData), .restartReq(restartReq),
    .irqAck(irqAck), .causeClr(causeClr), .ctlRd(ctlRd),
    .causeFlag_q(causeFlag_q), .irqReq_q(irqReq_q),
    .sysReset_q(sysReset_q));

  wdtru_core_model u_core (
    .mclk(mclk), .ctlWrData(ctlWrData), .ctlWrEn(ctlWrEn),
    .restartReq(restartReq), .irqAck(irqAck), .causeClr(causeClr));

  initial mclk = 1'b0;
  always #12.5 mclk = ~mclk;
  always @(negedge mclk) if (sysReset_q === 1'b1) nRst++;

  // ==========================================================
  // Model, checks and closing
  // ==========================================================
  function automatic wdtru_pkg::wdtru_ctl_s cur();
    cur = {mF[0], mIe[0], 1'b0, mRe[0], mSel[3:0]};
  endfunction

  task automatic chk_ctl(input string what, input logic ce);
    wdtru_pkg::wdtru_ctl_s e;
    e          = cur();
    e.changeEn = ce;
    nCompared++;
    if (ctlRd !== e) begin
      errors++;
      $display("unexpected %s exp %h got %h", what, e, ctlRd);
    end
  endtask

  task automatic chk_bit(input string what, input logic e, input logic g);
    nCompared++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %b got %b", what, e, g);
    end
  endtask

  // Tolerance covers the divider phase and the flag latency
  task automatic chk_time(input string what, input int e, input int g);
    nCompared++;
    if (g > e + TDIV + 4 || g < e - TDIV - 4) begin
      errors++;
      $display("unexpected %s exp %0d got %0d", what, e, g);
    end
  endtask

  task automatic wait_evt(input int rst, output int cnt);
    cnt = 0;
    while (cnt < 20000 &&
           ((rst != 0 ? sysReset_q : ctlRd.irqFlag) !== 1'b1)) begin
      @(negedge mclk);
      cnt++;
    end
  endtask

  task automatic test_done;
    $display("compared %0d mismatches %0d", nCompared, errors);
    if (errors == 0 && nCompared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge mclk);
    errors++;
    test_done();
  end

  // ==========================================================
  // Scenarios
  // ==========================================================
  initial begin
    seed = 62302;
    {errors, nCompared, nRst, mF, mIe, mRe, mSel} = '0;
    reset_n       = 1'b0;
    alwaysOnFuseN = 1'b1;
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    chk_ctl("ctl after reset", 1'b0);
    chk_bit("cause after reset", 1'b0, causeFlag_q);
    repeat (4) begin
      d = 8'($random(seed));
      {d.changeEn, d.resetEn, d.irqEn} = 3'h0;
      u_core.write(d);
      chk_ctl("plain store", 1'b0);
    end
    d = '0;
    {d.changeEn, d.resetEn} = 2'h3;
    u_core.write(d);
    mRe = 1;
    chk_ctl("window open", 1'b1);
    repeat (3) begin
      @(negedge mclk);
      chk_ctl("window open", 1'b1);
    end
    @(negedge mclk);
    chk_ctl("window closed", 1'b0);
    d = '0;
    d.tmoSel = 4'h2;
    u_core.write(d);
    chk_ctl("late step two", 1'b0);
    d = '0;
    d.irqEn  = 1'b1;
    d.tmoSel = 4'h1;
    u_core.timed(cur(), d);
    mIe  = 1;
    mRe  = 0;
    mSel = 1;
    chk_ctl("timed change", 1'b0);
    // Interrupt mode: a mid-period restart must delay the flag
    u_core.pulse(0);
    repeat (3000 + ($random(seed) & 4095)) @(negedge mclk);
    u_core.pulse(0);
    tmoQ.push_back(TDIV * (2048 << mSel));
    wait_evt(0, n);
    chk_time("irq period", tmoQ.pop_front(), n);
    mF = 1;
    chk_ctl("irq flag", 1'b0);
    @(negedge mclk);
    chk_bit("irq request", 1'b1, irqReq_q);
    chk_bit("no reset in irq mode", 1'b0, logic'(nRst != 0));
    u_core.pulse(1);
    mF = 0;
    chk_ctl("vector in irq mode", 1'b0);
    u_core.write('0);
    mIe = 0;
    // Reset mode with the shortest period
    d = '0;
    d.resetEn = 1'b1;
    u_core.timed(cur(), d);
    mRe  = 1;
    mSel = 0;
    chk_ctl("reset mode", 1'b0);
    u_core.pulse(0);
    tmoQ.push_back(TDIV * 2048);
    wait_evt(1, n);
    chk_time("reset period", tmoQ.pop_front(), n);
    @(negedge mclk);
    chk_bit("reset pulse width", 1'b0, sysReset_q);
    chk_bit("single pulse", 1'b1, logic'(nRst == 1));
    chk_bit("cause flag", 1'b1, causeFlag_q);
    chk_ctl("after watchdog reset", 1'b0);
    u_core.timed(cur(), '0);
    chk_ctl("cause holds enable", 1'b0);
    u_core.pulse(2);
    chk_bit("cause cleared", 1'b0, causeFlag_q);
    u_core.timed(cur(), '0);
    mRe = 0;
    chk_ctl("enable cleared", 1'b0);
    // Combined mode: interrupt first, reset on the next expiry
    d = '0;
    {d.irqEn, d.resetEn} = 2'h3;
    u_core.write(d);
    mIe = 1;
    mRe = 1;
    u_core.pulse(0);
    wait_evt(0, n);
    chk_time("combined period", TDIV * 2048, n);
    mF = 1;
    chk_ctl("combined first", 1'b0);
    chk_bit("no reset yet", 1'b1, logic'(nRst == 1));
    u_core.pulse(1);
    mF  = 0;
    mIe = 0;
    chk_ctl("combined vector", 1'b0);
    wait_evt(1, n);
    chk_bit("combined reset", 1'b1, sysReset_q);
    u_core.pulse(2);
    u_core.timed(cur(), '0);
    mRe = 0;
    chk_ctl("combined cleared", 1'b0);
    // A one-cycle pin glitch is filtered by the synchroniser
    alwaysOnFuseN = 1'b0;
    @(negedge mclk);
    alwaysOnFuseN = 1'b1;
    repeat (5) @(negedge mclk);
    chk_ctl("fuse glitch", 1'b0);
    // Fuse programmed: enables locked whatever is written
    alwaysOnFuseN = 1'b0;
    repeat (6) @(negedge mclk);
    mRe = 1;
    chk_ctl("fuse forces", 1'b0);
    d = '0;
    d.irqEn  = 1'b1;
    d.tmoSel = 4'($random(seed));
    u_core.timed(cur(), d);
    mSel = d.tmoSel;
    chk_ctl("fuse holds", 1'b0);
    test_done();
  end
endmodule
